// [rtl/clkbuf_defines.svh]
`ifndef CLKBUF_DEFINES_SVH
`define CLKBUF_DEFINES_SVH
`define REG_CTRL0 7'h00
`define REG_OE_LOW 7'h01
`define REG_OE_MID 7'h02
`define REG_PIN_RB 7'h03
`define REG_RSVD 7'h04
`define NUM_REGS 7'h05
`define CMD_BYTE_BIT 7
`define CTRL0_FREQ_BIT 0
`define CTRL0_OE_LSB 3
`define CTRL0_MODE_LSB 6
`define CTRL0_WMASK 8'h38
`define OE_RESET 8'hFF
`define CTRL0_OE_RESET 3'h7
`define SLAVE_ADDR_DEFAULT 7'h6C
`define BLOCK_COUNT_MAX 6'h20
`define BLOCK_READ_COUNT 6'h05
`define MODE_LOW_BW 2'h0
`define MODE_BYPASS 2'h1
`define MODE_HIGH_BW 2'h3
`endif

// [rtl/clkbuf_pkg.sv]
package clkbuf_pkg;
    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_ADDR = 9'h002,
        S_CMD = 9'h004,
        S_COUNT = 9'h008,
        S_WDATA = 9'h010,
        S_RCOUNT = 9'h020,
        S_RDATA = 9'h040,
        S_RACK = 9'h080,
        S_IGNORE = 9'h100
    } link_state_t;
    typedef enum logic [1:0] {
        STRAP_LOW = 2'h0,
        STRAP_MID = 2'h1,
        STRAP_HIGH = 2'h2
    } tri_level_t;
    typedef struct packed {
        logic scl;
        logic sda;
    } smbus_in_t;
endpackage : clkbuf_pkg

// [rtl/smbus_clock_buffer_regs.sv]
// Overview of operation
// - command byte names target register index
// - byte read: restart, device sends data
// - command bit 7: set byte, clear block
// - block: byte after command is count
// - block read: device acks command index
// - block read: device sends count first
// - block write: low seven bits index
// - command zero starts at register zero
// - device acks write bytes within the count; a count of 0 or over 32 is not acked
// - byte 0 bits 0,6,7 read-only straps
// - byte 0 bits 3-5 enable pairs 16-18
// - byte 1 enables pairs 0-7, default one
// - byte 2 enables pairs 8-15, default one
// - byte 3 shows live enable pins 5-12
// - byte 4 reserved, reads zero
// - mode readback encodes tri-level strap
// - power down: release bus, keep registers
// - general call address not answered
`timescale 1ns/1ps
`include "clkbuf_defines.svh"
module smbus_clock_buffer_regs #(
    parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEFAULT
) (
    input wire logic clock,
    input wire logic rstn,
    input wire clkbuf_pkg::smbus_in_t bus_in,
    output logic sda_oe_q,
    input wire logic power_good_latch,
    input wire logic frequency_select_strap,
    input wire clkbuf_pkg::tri_level_t pll_bandwidth_strap,
    input wire logic [7:0] enable_pin_level_bit,
    output logic [18:0] clock_output_pair_en_q,
    output logic [1:0] pll_mode_readback_q,
    output logic freq_readback_q
);
    import clkbuf_pkg::*;

    logic [1:0] scl_s_q, sda_s_q, pg_s_q, fs_s_q;
    logic [1:0] bw0_s_q, bw1_s_q;
    logic [7:0] pin_s0_q, pin_s1_q;
    logic scl_d1_q, sda_d1_q;
    logic scl_rise, scl_fall, start_det, stop_det;
    link_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic read_q, block_q, ack_phase_q;
    logic [6:0] index_q;
    logic [5:0] count_q;
    logic pg_seen_q;
    logic [7:0] ctrl_oe_low_q, ctrl_oe_mid_q;
    logic [2:0] ctrl_oe_high_q;
    logic [7:0] tx_q;
    logic byte_done;
    logic wr_strobe;
    logic host_ack;

    // two-stage synchronisers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            pg_s_q <= 2'h0;
            fs_s_q <= 2'h0;
            bw0_s_q <= 2'h0;
            bw1_s_q <= 2'h0;
            pin_s0_q <= 8'h00;
            pin_s1_q <= 8'h00;
        end else begin
            scl_s_q <= {scl_s_q[0], bus_in.scl};
            sda_s_q <= {sda_s_q[0], bus_in.sda};
            pg_s_q <= {pg_s_q[0], power_good_latch};
            fs_s_q <= {fs_s_q[0], frequency_select_strap};
            bw0_s_q <= {bw0_s_q[0], pll_bandwidth_strap[0]};
            bw1_s_q <= {bw1_s_q[0], pll_bandwidth_strap[1]};
            pin_s0_q <= enable_pin_level_bit;
            pin_s1_q <= pin_s0_q;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end else begin
            scl_d1_q <= scl_s_q[1];
            sda_d1_q <= sda_s_q[1];
        end
    end

    assign scl_rise = scl_s_q[1] && !scl_d1_q;
    assign scl_fall = !scl_s_q[1] && scl_d1_q;
    assign start_det = scl_s_q[1] && scl_d1_q && !sda_s_q[1] && sda_d1_q;
    assign stop_det = scl_s_q[1] && scl_d1_q && sda_s_q[1] && !sda_d1_q;
    assign byte_done = scl_fall && bit_cnt_q == 4'h8 && !ack_phase_q;
    // host ack finds data line released; own address ack does not
    assign host_ack = scl_rise && ack_phase_q && read_q && !sda_oe_q;

    // straps caught on first power-good rise
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pg_seen_q <= 1'b0;
            freq_readback_q <= 1'b0;
            pll_mode_readback_q <= `MODE_LOW_BW;
        end else if (pg_s_q[1] && !pg_seen_q) begin
            pg_seen_q <= 1'b1;
            freq_readback_q <= fs_s_q[1];
            case ({bw1_s_q[1], bw0_s_q[1]})
                STRAP_MID: pll_mode_readback_q <= `MODE_BYPASS;
                STRAP_HIGH: pll_mode_readback_q <= `MODE_HIGH_BW;
                default: pll_mode_readback_q <= `MODE_LOW_BW;
            endcase
        end
    end

    function automatic logic [7:0] reg_read(input logic [6:0] idx);
        case (idx)
            `REG_CTRL0: reg_read = {pll_mode_readback_q, ctrl_oe_high_q, 2'h0, freq_readback_q};
            `REG_OE_LOW: reg_read = ctrl_oe_low_q;
            `REG_OE_MID: reg_read = ctrl_oe_mid_q;
            `REG_PIN_RB: reg_read = pin_s1_q;
            default: reg_read = 8'h00;
        endcase
    endfunction : reg_read

    // bit counter and shifter; acks take the ninth clock
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ack_phase_q <= 1'b0;
        end else if (start_det || stop_det) begin
            bit_cnt_q <= 4'h0;
            ack_phase_q <= 1'b0;
        end else if (scl_rise) begin
            if (!ack_phase_q) begin
                shift_q <= {shift_q[6:0], sda_s_q[1]};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end else if (scl_fall) begin
            if (byte_done) begin
                ack_phase_q <= 1'b1;
            end else if (ack_phase_q) begin
                ack_phase_q <= 1'b0;
                bit_cnt_q <= 4'h0;
            end
        end
    end

    // transaction state machine
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_IDLE;
            read_q <= 1'b0;
            block_q <= 1'b0;
            index_q <= 7'h00;
            count_q <= 6'h00;
        end else if (!pg_s_q[1] || stop_det) begin
            state_q <= S_IDLE;
        end else if (start_det) begin
            state_q <= S_ADDR;
        end else if (byte_done) begin
            case (state_q)
                S_ADDR: begin
                    read_q <= shift_q[0];
                    if (shift_q[7:1] != SLAVE_ADDR) begin
                        state_q <= S_IGNORE;
                    end else if (shift_q[0]) begin
                        state_q <= block_q ? S_RCOUNT : S_RDATA;
                    end else begin
                        state_q <= S_CMD;
                    end
                end
                S_CMD: begin
                    index_q <= shift_q[6:0];
                    // bit 7 picks byte or block
                    block_q <= !shift_q[`CMD_BYTE_BIT];
                    state_q <= shift_q[`CMD_BYTE_BIT] ? S_WDATA : S_COUNT;
                    count_q <= 6'h01;
                end
                S_COUNT: begin
                    count_q <= shift_q[5:0];
                    state_q <= (shift_q == 8'h00 || shift_q > {2'h0, `BLOCK_COUNT_MAX}) ?
                        S_IGNORE : S_WDATA;
                end
                S_WDATA: begin
                    index_q <= index_q + 7'h1;
                    count_q <= count_q - 6'h1;
                    if (count_q == 6'h01) begin
                        state_q <= S_IGNORE;
                    end
                end
                default: state_q <= state_q;
            endcase
        end else if (host_ack) begin
            case (state_q)
                S_RCOUNT: state_q <= S_RDATA;
                S_RDATA: begin
                    index_q <= index_q + 7'h1;
                    if (sda_s_q[1]) begin
                        state_q <= S_IGNORE;
                    end
                end
                default: state_q <= state_q;
            endcase
        end
    end

    assign wr_strobe = byte_done && state_q == S_WDATA;

    // enable registers, kept through power down
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_oe_low_q <= `OE_RESET;
            ctrl_oe_mid_q <= `OE_RESET;
            ctrl_oe_high_q <= `CTRL0_OE_RESET;
        end else if (wr_strobe) begin
            case (index_q)
                `REG_CTRL0: ctrl_oe_high_q <= shift_q[5:3];
                `REG_OE_LOW: ctrl_oe_low_q <= shift_q;
                `REG_OE_MID: ctrl_oe_mid_q <= shift_q;
                default: ctrl_oe_high_q <= ctrl_oe_high_q;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clock_output_pair_en_q <= 19'h7FFFF;
        end else begin
            clock_output_pair_en_q <= {ctrl_oe_high_q, ctrl_oe_mid_q, ctrl_oe_low_q};
        end
    end

    // transmit byte loads on entry to each read byte
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tx_q <= 8'h00;
        end else if (byte_done && state_q == S_ADDR) begin
            tx_q <= block_q ? {2'h0, `BLOCK_READ_COUNT} : reg_read(index_q);
        end else if (host_ack) begin
            tx_q <= state_q == S_RCOUNT ? reg_read(index_q) : reg_read(index_q + 7'h1);
        end else if (scl_fall && !ack_phase_q && bit_cnt_q != 4'h0 && bit_cnt_q != 4'h8) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // data pin drive, updated on scl low
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sda_oe_q <= 1'b0;
        end else if (!pg_s_q[1] || stop_det || start_det) begin
            sda_oe_q <= 1'b0;
        end else if (scl_fall) begin
            if (byte_done) begin
                sda_oe_q <= state_q inside {S_ADDR, S_CMD, S_COUNT, S_WDATA} &&
                    !(state_q == S_ADDR && shift_q[7:1] != SLAVE_ADDR) &&
                    !(state_q == S_COUNT && (shift_q == 8'h00 ||
                      shift_q > {2'h0, `BLOCK_COUNT_MAX}));
            end else if (read_q && (state_q == S_RDATA || state_q == S_RCOUNT) &&
                         (ack_phase_q || bit_cnt_q != 4'h8)) begin
                sda_oe_q <= ack_phase_q ? !tx_q[7] : (bit_cnt_q == 4'h0 ? !tx_q[7] : !tx_q[6]);
            end else begin
                sda_oe_q <= 1'b0;
            end
        end
    end

    a_cnt_sent_first: assert property (@(posedge clock) disable iff (!rstn)
        (byte_done && state_q == S_ADDR && shift_q[0] && block_q &&
         shift_q[7:1] == SLAVE_ADDR) |=> tx_q == 8'h05)
        else $error("block read count not loaded");
    a_rsvd_zero_read: assert property (@(posedge clock) disable iff (!rstn)
        host_ack && state_q == S_RDATA && index_q + 7'h1 == `REG_RSVD |=> tx_q == 8'h00)
        else $error("reserved byte not zero");
    a_strap_bits_fixed: assert property (@(posedge clock) disable iff (!rstn)
        pg_seen_q && $past(pg_seen_q) |-> $stable(pll_mode_readback_q) && $stable(freq_readback_q))
        else $error("strap readback changed");
    a_mode_code_legal: assert property (@(posedge clock) disable iff (!rstn)
        pll_mode_readback_q != 2'h2)
        else $error("illegal mode readback code");
    a_index_advance: assert property (@(posedge clock) disable iff (!rstn)
        wr_strobe |=> index_q == $past(index_q) + 7'h1)
        else $error("index did not advance");
    a_write_ack_drive: assert property (@(posedge clock) disable iff (!rstn)
        wr_strobe && pg_s_q[1] && !stop_det && !start_det |=> sda_oe_q)
        else $error("write byte not acked");
    a_power_down_n_release: assert property (@(posedge clock) disable iff (!rstn)
        !pg_s_q[1] |=> !sda_oe_q && state_q == S_IDLE)
        else $error("bus driven in power down");
    a_low_enable_map: assert property (@(posedge clock) disable iff (!rstn)
        clock_output_pair_en_q[15:0] == $past({ctrl_oe_mid_q, ctrl_oe_low_q}))
        else $error("enable map wrong");
    a_cmd_block_flag: assert property (@(posedge clock) disable iff (!rstn)
        byte_done && state_q == S_CMD && !start_det && !stop_det && pg_s_q[1]
        |=> block_q == !$past(shift_q[7]))
        else $error("command type decode wrong");
    a_count_refused: assert property (@(posedge clock) disable iff (!rstn)
        byte_done && state_q == S_COUNT && pg_s_q[1] &&
        (shift_q == 8'h00 || shift_q > {2'h0, `BLOCK_COUNT_MAX})
        |=> state_q == S_IGNORE && !sda_oe_q)
        else $error("bad block count accepted");
    a_foreign_addr_nak: assert property (@(posedge clock) disable iff (!rstn)
        byte_done && state_q == S_ADDR && shift_q[7:1] != SLAVE_ADDR |=> !sda_oe_q)
        else $error("foreign address acknowledged");
    a_cmd_index_load: assert property (@(posedge clock) disable iff (!rstn)
        byte_done && state_q == S_CMD && pg_s_q[1] |=> index_q == $past(shift_q[6:0]))
        else $error("start index not taken from command");
    a_byte0_oe_write: assert property (@(posedge clock) disable iff (!rstn)
        wr_strobe && index_q == `REG_CTRL0 |=> ctrl_oe_high_q == $past(shift_q[5:3]))
        else $error("byte 0 enables not written");
    a_host_nak_end: assert property (@(posedge clock) disable iff (!rstn)
        host_ack && state_q == S_RDATA && sda_s_q[1] && pg_s_q[1] |=> state_q == S_IGNORE)
        else $error("read went on after host nak");
    a_byte_write_one: assert property (@(posedge clock) disable iff (!rstn)
        wr_strobe && !block_q && pg_s_q[1] |=> state_q == S_IGNORE)
        else $error("byte write took a second byte");
endmodule : smbus_clock_buffer_regs

// [verification/smbus_host_model.sv]
`timescale 1ns/1ps
module smbus_host_model (
    input wire logic clock,
    input wire logic sda_oe_q,
    output clkbuf_pkg::smbus_in_t bus_in
);
    import clkbuf_pkg::*;
    logic scl_q;
    logic pull_q;
    // open-drain data line with pull-up
    assign bus_in.scl = scl_q;
    assign bus_in.sda = ~(pull_q | sda_oe_q);
    initial begin
        scl_q = 1'b1;
        pull_q = 1'b0;
    end
    task automatic phase();
        repeat (8) @(posedge clock);
    endtask : phase
    // start, also used as repeated start
    task automatic start();
        pull_q <= 1'b0;
        phase();
        scl_q <= 1'b1;
        phase();
        pull_q <= 1'b1;
        phase();
        scl_q <= 1'b0;
        phase();
    endtask : start
    task automatic stop();
        pull_q <= 1'b1;
        phase();
        scl_q <= 1'b1;
        phase();
        pull_q <= 1'b0;
        phase();
    endtask : stop
    task automatic bit_io(input logic b, output logic r);
        pull_q <= ~b;
        phase();
        scl_q <= 1'b1;
        phase();
        r = bus_in.sda;
        scl_q <= 1'b0;
        phase();
    endtask : bit_io
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : send_byte
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask : recv_byte
endmodule : smbus_host_model

// [verification/smbus_clock_buffer_regs_tb_top.sv]
`timescale 1ns/1ps
`include "clkbuf_defines.svh"
module smbus_clock_buffer_regs_tb_top;
    import clkbuf_pkg::*;
    localparam logic [6:0] ADDR = 7'h6C;
    logic clock;
    logic rstn;
    smbus_in_t bus_in;
    logic sda_oe_q;
    logic power_good_latch;
    logic frequency_select_strap;
    tri_level_t pll_bandwidth_strap;
    logic [7:0] enable_pin_level_bit;
    logic [18:0] clock_output_pair_en_q;
    logic [1:0] pll_mode_readback_q;
    logic freq_readback_q;
    int errors;
    int compares;
    tri_level_t lvls[3] = '{STRAP_LOW, STRAP_MID, STRAP_HIGH};
    logic [1:0] mexp[3] = '{2'h0, 2'h1, 2'h3};
    smbus_clock_buffer_regs #(.SLAVE_ADDR(ADDR)) dut (
        .clock(clock), .rstn(rstn), .bus_in(bus_in), .sda_oe_q(sda_oe_q),
        .power_good_latch(power_good_latch), .frequency_select_strap(frequency_select_strap),
        .pll_bandwidth_strap(pll_bandwidth_strap), .enable_pin_level_bit(enable_pin_level_bit),
        .clock_output_pair_en_q(clock_output_pair_en_q),
        .pll_mode_readback_q(pll_mode_readback_q), .freq_readback_q(freq_readback_q));
    smbus_host_model host (.clock(clock), .sda_oe_q(sda_oe_q), .bus_in(bus_in));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic cmp_data(input string name, input logic [18:0] exp, input logic [18:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_data
    task automatic cmp_ack(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask : cmp_ack
    task automatic boot(input tri_level_t lvl, input logic f);
        @(posedge clock);
        rstn <= 1'b0;
        power_good_latch <= 1'b0;
        pll_bandwidth_strap <= lvl;
        frequency_select_strap <= f;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        power_good_latch <= 1'b1;
        repeat (8) @(posedge clock);
    endtask : boot
    task automatic head(input logic [7:0] cmd);
        logic a;
        host.start();
        host.send_byte({ADDR, 1'b0}, a);
        cmp_ack("addr ack", 1'b1, a);
        host.send_byte(cmd, a);
        cmp_ack("cmd ack", 1'b1, a);
    endtask : head
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d[$]);
        logic a;
        head(cmd);
        if (!cmd[7]) begin
            host.send_byte(8'(d.size()), a);
            cmp_ack("count ack", 1'b1, a);
        end
        foreach (d[i]) begin
            host.send_byte(d[i], a);
            cmp_ack("data ack", 1'b1, a);
        end
        host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] cmd, input logic [7:0] e[$]);
        logic a;
        logic [7:0] v;
        head(cmd);
        host.start();
        host.send_byte({ADDR, 1'b1}, a);
        cmp_ack("read addr ack", 1'b1, a);
        if (!cmd[7]) begin
            host.recv_byte(1'b0, v);
            cmp_data("block count", 19'(`BLOCK_READ_COUNT), 19'(v));
        end
        foreach (e[i]) begin
            host.recv_byte(i == e.size() - 1, v);
            cmp_data("read byte", 19'(e[i]), 19'(v));
        end
        host.stop();
    endtask : rd
    task automatic nak_addr(input logic [7:0] adr);
        logic a;
        host.start();
        host.send_byte(adr, a);
        cmp_ack("foreign addr", 1'b0, a);
        host.stop();
    endtask : nak_addr
    task automatic bad_count(input logic [7:0] n);
        logic a;
        head(8'h01);
        host.send_byte(n, a);
        cmp_ack("bad count", 1'b0, a);
        host.send_byte(8'h00, a);
        cmp_ack("after bad count", 1'b0, a);
        host.stop();
    endtask : bad_count
    initial begin
        repeat (80000) @(posedge clock);
        errors++;
        print_verdict();
    end
    initial begin
        errors = 0;
        compares = 0;
        rstn = 1'b0;
        power_good_latch = 1'b0;
        frequency_select_strap = 1'b0;
        pll_bandwidth_strap = STRAP_LOW;
        enable_pin_level_bit = 8'h96;
        foreach (lvls[k]) begin
            boot(lvls[k], k[0]);
            cmp_data("mode", 19'(mexp[k]), 19'(pll_mode_readback_q));
            cmp_data("freq", 19'(k[0]), 19'(freq_readback_q));
            cmp_data("enables", 19'h7FFFF, clock_output_pair_en_q);
        end
        wr(8'h81, '{8'h0F});
        cmp_data("pairs 0-7", 19'h7FF0F, clock_output_pair_en_q);
        rd(8'h81, '{8'h0F});
        wr(8'h80, '{8'h00});
        cmp_data("pairs 16-18", 19'h0FF0F, clock_output_pair_en_q);
        rd(8'h80, '{8'hC0});
        wr(8'h00, '{8'h38, 8'hA5, 8'h5A});
        cmp_data("block write", 19'h75AA5, clock_output_pair_en_q);
        wr(8'h02, '{8'h3C});
        cmp_data("pairs 8-15", 19'h73CA5, clock_output_pair_en_q);
        wr(8'h83, '{8'hFF});
        cmp_data("pin byte write", 19'h73CA5, clock_output_pair_en_q);
        wr(8'h84, '{8'hFF});
        cmp_data("reserved write", 19'h73CA5, clock_output_pair_en_q);
        bad_count(8'h00);
        bad_count(8'h21);
        cmp_data("bad count kept", 19'h73CA5, clock_output_pair_en_q);
        rd(8'h00, '{8'hF8, 8'hA5, 8'h3C, 8'h96, 8'h00});
        enable_pin_level_bit <= 8'h69;
        rd(8'h83, '{8'h69});
        nak_addr(8'h00);
        nak_addr(8'hDA);
        power_good_latch <= 1'b0;
        repeat (8) @(posedge clock);
        nak_addr({ADDR, 1'b0});
        power_good_latch <= 1'b1;
        repeat (8) @(posedge clock);
        rd(8'h82, '{8'h3C});
        print_verdict();
    end
endmodule : smbus_clock_buffer_regs_tb_top
